/* File: rtl/axss_sync_start.sv */
/*
 Synchronized start logic for two pulse axes: position and speed modes.
 Assumes request and stop pulses come from logic on the same scan clock;
 speed and position feeds are valid every cycle.
*/
// What this block does
// - Request edge arms follower under chosen leader
// - Armed follower emits no pulses, shows busy
// - Start follower step when leader reaches target
// - No origin refuses: leader 346, follower 344
// - Same leader and follower refused, code 347
// - Decel stop to follower cancels pending start
// - Leader already armed follower refused, 349
// - Speed request arms follower, tracks leader ratio
// - Speed leader select: axes, then counters 0-7
// - Ratio 1..10000 in hundredths of percent
// - Delay 1..10 milliseconds to reach speed
// - Sample leader speed every 500 us, ramp
// - Ratio out of range refused, code 356
// - Delay out of range refused, code 357
// - Speed leader select out of range, 355
`timescale 1ns/1ps
module axss_sync_start
    import axss_pkg::*;
#(
    parameter int SAMPLE_CNT = SAMPLE_CYCLES,
    parameter int MS_CNT     = MS_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [1:0]        position_sync_start_cmd,
    input  wire logic [1:0]        speed_sync_start_cmd,
    input  wire logic [1:0]        decel_stop_cmd,
    input  wire axss_req_type      req,
    input  wire logic [1:0]        origin_set,
    input  wire logic [63:0]       axis_position,
    input  wire logic [63:0]       axis_speed,
    input  wire logic [255:0]      counter_speed,
    output logic [1:0]             follower_inhibit,
    output logic [1:0]             follower_busy,
    output logic [1:0]             step_start,
    output logic [6:0]             step_number,
    output logic [1:0]             speed_valid,
    output logic [63:0]            follower_speed,
    output logic                   done,
    output logic [15:0]            status
);
    axss_mode_type mode [2];
    axss_mode_type next_mode [2];
    axss_req_type  par [2];
    axss_req_type  next_par [2];
    logic [1:0]    pos_q, spd_q;
    logic [31:0]   tick, next_tick;
    logic [31:0]   cur_spd [2];
    logic [31:0]   next_cur_spd [2];
    logic [31:0]   last_goal [2];
    logic [31:0]   next_last_goal [2];
    logic [31:0]   ramp_left [2];
    logic [31:0]   next_ramp_left [2];
    logic [1:0]    next_step_start;
    logic [6:0]    next_step_number;
    logic          next_done;
    logic [15:0]   next_status;

    // select decode, axes then counters
    // Leader speed of a speed-mode source, axis or counter channel
    function automatic logic [31:0] lead_speed(input logic [7:0] sel,
                                               input logic [63:0] ax,
                                               input logic [255:0] hc);
        logic [7:0] ch;
        ch = sel - HSC_BASE;
        if (sel < HSC_BASE)
            lead_speed = ax[sel[0]*32 +: 32];
        else
            lead_speed = hc[ch[2:0]*32 +: 32];
    endfunction

    // Next state for both followers and the shared answer port
    always_comb begin
        logic [1:0]  pos_edge;
        logic [1:0]  spd_edge;
        logic        f;
        logic        l;
        logic [47:0] prod;
        logic [31:0] goal;
        logic [31:0] steps;
        logic [31:0] left;
        pos_edge = position_sync_start_cmd & ~pos_q;
        spd_edge = speed_sync_start_cmd & ~spd_q;
        f = req.follower;
        l = req.leader[0];
        prod = '0;
        goal = '0;
        steps = '0;
        left = '0;
        next_mode = mode;
        next_par = par;
        next_cur_spd = cur_spd;
        next_last_goal = last_goal;
        next_ramp_left = ramp_left;
        next_tick = (tick >= 32'(SAMPLE_CNT - 1)) ? '0 : tick + 32'h0000_0001;
        next_step_start = '0;
        next_step_number = step_number;
        next_done = 1'b0;
        next_status = status;
        for (int a = 0; a < 2; a++) begin
            case (mode[a])
                AXSS_POS_WAIT: begin
                    if (axis_position[par[a].leader[0]*32 +: 32]
                        == par[a].target) begin
                        next_mode[a] = AXSS_IDLE;
                        next_step_start[a] = 1'b1;
                        next_step_number = par[a].step;
                    end
                end
                AXSS_SPD_WAIT: begin
                    if (lead_speed(par[a].leader, axis_speed, counter_speed)
                        != '0)
                        next_mode[a] = AXSS_SPD_RUN;
                end
                AXSS_SPD_RUN: begin
                    if (tick == '0) begin
                        prod = 48'(lead_speed(par[a].leader, axis_speed,
                                   counter_speed)) * 48'(par[a].ratio);
                        goal = 32'(prod / 48'(RATIO_MAX));
                        steps = 32'(par[a].delay) * 32'(MS_CNT / SAMPLE_CNT);
                        // A new goal restarts the countdown, so the ramp is
                        // linear and lands on the goal after the delay
                        left = (goal != last_goal[a]) ? steps : ramp_left[a];
                        // Floor of one also guards a zero ramp length
                        if (left == '0)
                            left = 32'h0000_0001;
                        next_last_goal[a] = goal;
                        next_ramp_left[a] = left - 32'h0000_0001;
                        if (goal > cur_spd[a])
                            next_cur_spd[a] = cur_spd[a] +
                                (goal - cur_spd[a] + left - 32'h0000_0001)
                                / left;
                        else
                            next_cur_spd[a] = cur_spd[a] -
                                (cur_spd[a] - goal + left - 32'h0000_0001)
                                / left;
                    end
                end
                default: next_mode[a] = AXSS_IDLE;
            endcase
            if (decel_stop_cmd[a]) begin
                next_mode[a] = AXSS_IDLE;
                next_cur_spd[a] = '0;
                next_last_goal[a] = '0;
                next_ramp_left[a] = '0;
            end
        end
        if (pos_edge != '0) begin
            next_done = 1'b1;
            if (l == f)
                next_status = ERR_SAME_AXIS;
            else if (!origin_set[l])
                next_status = ERR_LEAD_ORIGIN;
            else if (!origin_set[f])
                next_status = ERR_FOL_ORIGIN;
            else if (mode[l] == AXSS_POS_WAIT)
                next_status = ERR_LEAD_ARMED;
            else begin
                next_status = STAT_OK;
                next_mode[f] = AXSS_POS_WAIT;
                next_par[f] = req;
            end
        end else if (spd_edge != '0) begin
            next_done = 1'b1;
            if (req.leader > SPD_SEL_MAX ||
                (req.leader < HSC_BASE && l == f))
                next_status = ERR_SPD_LEADER;
            else if (req.ratio < RATIO_MIN || req.ratio > RATIO_MAX)
                next_status = ERR_SPD_RATIO;
            else if (req.delay < DELAY_MIN || req.delay > DELAY_MAX)
                next_status = ERR_SPD_DELAY;
            else begin
                next_status = STAT_OK;
                next_mode[f] = AXSS_SPD_WAIT;
                next_par[f] = req;
                next_cur_spd[f] = '0;
                next_last_goal[f] = '0;
                next_ramp_left[f] = '0;
            end
        end
    end

    // Registers; done pulses for one scan, status holds the answer until the next request
    always_ff @(posedge clk) begin
        if (reset) begin
            mode <= '{AXSS_IDLE, AXSS_IDLE};
            par <= '{default: '0};
            cur_spd <= '{default: '0};
            last_goal <= '{default: '0};
            ramp_left <= '{default: '0};
            pos_q <= '0;
            spd_q <= '0;
            tick <= '0;
            step_start <= '0;
            step_number <= '0;
            done <= 1'b0;
            status <= STAT_OK;
        end else begin
            mode <= next_mode;
            par <= next_par;
            cur_spd <= next_cur_spd;
            last_goal <= next_last_goal;
            ramp_left <= next_ramp_left;
            pos_q <= position_sync_start_cmd;
            spd_q <= speed_sync_start_cmd;
            tick <= next_tick;
            step_start <= next_step_start;
            step_number <= next_step_number;
            done <= next_done; // one scan
            status <= next_status;
        end
    end

    always_comb begin
        for (int a = 0; a < 2; a++) begin
            follower_inhibit[a] = (mode[a] == AXSS_POS_WAIT) ||
                                  (mode[a] == AXSS_SPD_WAIT);
            follower_busy[a] = (mode[a] != AXSS_IDLE);
            speed_valid[a] = (mode[a] == AXSS_SPD_RUN);
            follower_speed[a*32 +: 32] = cur_spd[a];
        end
    end
endmodule

/* File: pkg/axss_pkg.sv */
/*
 Shared constants and carriers for the two-axis synchronized start block.
 Assumes a 100 MHz scan clock and two pulse axes plus eight counter channels.
*/
package axss_pkg;
    localparam int          CLK_MHZ         = 100;
    localparam int          SAMPLE_US       = 500;
    localparam int          SAMPLE_CYCLES   = SAMPLE_US * CLK_MHZ;
    localparam int          MS_CYCLES       = 1000 * CLK_MHZ;
    localparam logic [15:0] STAT_OK         = 16'h0000;
    localparam logic [15:0] ERR_FOL_ORIGIN  = 16'h0158; // 344
    localparam logic [15:0] ERR_LEAD_ORIGIN = 16'h015A; // 346
    localparam logic [15:0] ERR_SAME_AXIS   = 16'h015B; // 347
    localparam logic [15:0] ERR_LEAD_ARMED  = 16'h015D; // 349
    localparam logic [15:0] ERR_SPD_LEADER  = 16'h0163; // 355
    localparam logic [15:0] ERR_SPD_RATIO   = 16'h0164; // 356
    localparam logic [15:0] ERR_SPD_DELAY   = 16'h0165; // 357
    localparam logic [13:0] RATIO_MIN       = 14'h0001;
    localparam logic [13:0] RATIO_MAX       = 14'h2710; // 10000
    localparam logic [7:0]  DELAY_MIN       = 8'h01;
    localparam logic [7:0]  DELAY_MAX       = 8'h0A;
    localparam logic [7:0]  SPD_SEL_MAX     = 8'h09;
    localparam logic [7:0]  HSC_BASE        = 8'h02;

    typedef enum logic [1:0] {
        AXSS_IDLE,
        AXSS_POS_WAIT,
        AXSS_SPD_WAIT,
        AXSS_SPD_RUN
    } axss_mode_type;

    // Request parameters as captured at the request edge
    typedef struct packed {
        logic        follower;
        logic [7:0]  leader;
        logic [6:0]  step;
        logic [31:0] target;
        logic [13:0] ratio;
        logic [7:0]  delay;
    } axss_req_type;
endpackage

/* File: tb/axss_drive_model.sv */
/* Leader axis drive model: counts one pulse a cycle while it runs.
   Assumes run comes from the bench on the scan clock. */
`timescale 1ns/1ps
module axss_drive_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        run,
    output logic [31:0]      position,
    output logic [31:0]      speed
);
    logic [31:0] next_position;
    always_comb next_position = reset ? 32'h0000_0000 : position + 32'(run);
    always_ff @(posedge clk) position <= next_position;
    // A stopped drive reports zero speed, so the follower must wait
    assign speed = run ? 32'h0000_0064 : 32'h0000_0000;
endmodule

/* File: tb/axss_chk.sv */
/* Port checker for the synchronized start block.
   Assumes one scan clock and a synchronous active high reset. */
`timescale 1ns/1ps
module axss_chk
    import axss_pkg::*;
#(parameter int SAMPLE_CNT = SAMPLE_CYCLES, parameter int MS_CNT = MS_CYCLES) (
    input wire logic         clk,
    input wire logic         reset,
    input wire logic [1:0]   position_sync_start_cmd,
    input wire logic [1:0]   speed_sync_start_cmd,
    input wire logic [1:0]   decel_stop_cmd,
    input wire axss_req_type req,
    input wire logic [1:0]   origin_set,
    input wire logic [1:0]   follower_inhibit,
    input wire logic [1:0]   follower_busy,
    input wire logic [1:0]   step_start,
    input wire logic [1:0]   speed_valid,
    input wire logic         done,
    input wire logic [15:0]  status
);
    logic [3:0] prev, next_prev;
    logic       pe, se, ae, pair, hsc, rat;
    // Command history, cleared in reset so a held command counts as edge
    always_comb next_prev = reset ? 4'h0 :
        {position_sync_start_cmd, speed_sync_start_cmd};
    always_ff @(posedge clk) prev <= next_prev;
    // Request edges and argument classes
    assign pe = |(position_sync_start_cmd & ~prev[3:2]);
    assign se = |(speed_sync_start_cmd & ~prev[1:0]);
    assign ae = pe | se;
    assign pair = pe && req.leader[7:1] == 7'h00 &&
        req.leader[0] != req.follower;
    assign hsc = se && !pe && req.leader == HSC_BASE;
    assign rat = req.ratio >= RATIO_MIN && req.ratio <= RATIO_MAX;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    edge_done_a: assert property (ae |=> done)
        else $error("done missing after request");
    idle_done_a: assert property (!ae |=> !done)
        else $error("done without request");
    hold_status_a: assert property (!ae |=> $stable(status))
        else $error("status moved without request");
    same_axis_a: assert property (
        pe && req.leader == {7'h00, req.follower}
        |=> status == ERR_SAME_AXIS)
        else $error("same axis not refused");
    lead_origin_a: assert property (
        pair && !origin_set[req.leader[0]]
        |=> status == ERR_LEAD_ORIGIN)
        else $error("leader origin not refused");
    fol_origin_a: assert property (
        pair && origin_set[req.leader[0]] && !origin_set[req.follower]
        |=> status == ERR_FOL_ORIGIN)
        else $error("follower origin not refused");
    spd_select_a: assert property (
        se && !pe && req.leader > SPD_SEL_MAX
        |=> status == ERR_SPD_LEADER)
        else $error("leader select not refused");
    spd_ratio_a: assert property (
        hsc && !rat
        |=> status == ERR_SPD_RATIO)
        else $error("ratio not refused");
    spd_delay_a: assert property (
        hsc && rat && (req.delay < DELAY_MIN || req.delay > DELAY_MAX)
        |=> status == ERR_SPD_DELAY)
        else $error("delay not refused");
    wait_busy_a: assert property (
        (follower_inhibit & ~follower_busy) == 0)
        else $error("waiting follower not busy");
    stop_cancel_a: assert property (
        !ae && |(follower_inhibit & decel_stop_cmd)
        |=> (follower_busy & $past(decel_stop_cmd)) == 0)
        else $error("stop did not cancel");
    armed_start_a: assert property (
        (step_start & ~$past(follower_inhibit)) == 0)
        else $error("step start while not armed");
    run_free_a: assert property (
        (speed_valid & follower_inhibit) == 0)
        else $error("speed follower still held");
    cover property (step_start != 0);
    cover property (speed_valid != 0);
    cover property (ae ##1 status == ERR_LEAD_ARMED);
endmodule
bind axss_sync_start axss_chk #(
    .SAMPLE_CNT(SAMPLE_CNT),
    .MS_CNT(MS_CNT)
) chk_i (
    .clk(clk),
    .reset(reset),
    .position_sync_start_cmd(position_sync_start_cmd),
    .speed_sync_start_cmd(speed_sync_start_cmd),
    .decel_stop_cmd(decel_stop_cmd),
    .req(req),
    .origin_set(origin_set),
    .follower_inhibit(follower_inhibit),
    .follower_busy(follower_busy),
    .step_start(step_start),
    .speed_valid(speed_valid),
    .done(done),
    .status(status)
);

/* File: tb/tb_top.sv */
/* Bench for the synchronized start block with a leader drive model.
   Assumes the model drives axis 0; axis 1 stands still and counters move one at a time in the select loop. */
`timescale 1ns/1ps
module tb_top;
    import axss_pkg::*;
    logic         clk = 0, reset = 1, run = 0, done;
    logic [1:0]   pcmd = 0, scmd = 0, stop = 0, org = 2'h3;
    logic [1:0]   inh, busy, sst, sv;
    logic [6:0]   sn;
    logic [31:0]  lpos, lspd;
    logic [63:0]  fspd;
    logic [255:0] cspd = '0;
    logic [15:0]  status;
    axss_req_type req = '0;
    int           bad_count = 0, n_compared = 0, i;
    // Scan clock, 10 ns
    always #5 clk = ~clk;
    axss_sync_start #(.SAMPLE_CNT(10), .MS_CNT(20)) DUT (.clk(clk),
        .reset(reset), .position_sync_start_cmd(pcmd),
        .speed_sync_start_cmd(scmd), .decel_stop_cmd(stop), .req(req),
        .origin_set(org), .axis_position({32'h0000_0000, lpos}),
        .axis_speed({32'h0000_0000, lspd}), .counter_speed(cspd),
        .follower_inhibit(inh), .follower_busy(busy), .step_start(sst),
        .step_number(sn), .speed_valid(sv), .follower_speed(fspd),
        .done(done), .status(status));
    axss_drive_model M (.clk(clk), .reset(reset), .run(run),
        .position(lpos), .speed(lspd));
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // One request edge, answer one cycle later, then done drops
    task issue(input logic p, input logic f, input logic [7:0] l,
               input logic [15:0] exp);
        req.follower = f;
        req.leader = l;
        if (p) pcmd[f] = 1'h1;
        else scmd[f] = 1'h1;
        @(negedge clk);
        chk(done, 1'h1);
        chk(status, exp);
        pcmd = 0;
        scmd = 0;
        @(negedge clk);
        chk(done, 1'h0);
    endtask
    // Stop pulse on axis 1, so follower 1 is idle before the next request
    task halt;
        stop = 2'h2;
        @(negedge clk);
        stop = 0;
    endtask
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Main sequence, inputs change on falling edges
    initial begin
        repeat (3) @(negedge clk);
        reset = 0;
        issue(1, 1, 8'h01, ERR_SAME_AXIS);
        org = 2'h2;
        issue(1, 1, 8'h00, ERR_LEAD_ORIGIN);
        org = 2'h1;
        issue(1, 1, 8'h00, ERR_FOL_ORIGIN);
        org = 2'h3;
        // position leader select kept to 0 or 1
        req.target = 32'h0000_0014;
        req.step = 7'h50;
        issue(1, 1, 8'h00, STAT_OK);
        chk({inh, busy}, 4'hA);
        issue(1, 0, 8'h01, ERR_LEAD_ARMED);
        run = 1;
        for (i = 0; i < 100 && sst !== 2'h2; i++) @(negedge clk);
        chk(lpos, 32'h0000_0015);
        chk({sn, busy}, {7'h50, 2'h0});
        req.target = 32'h8000_0000;
        issue(1, 1, 8'h00, STAT_OK);
        halt();
        chk(busy, 2'h0);
        run = 0;
        req.delay = 8'h05;
        issue(0, 1, 8'h02, ERR_SPD_RATIO);
        req.ratio = 14'h2711;
        issue(0, 1, 8'h02, ERR_SPD_RATIO);
        req.ratio = 14'h2710;
        req.delay = 8'h00;
        issue(0, 1, 8'h02, ERR_SPD_DELAY);
        req.delay = 8'h0B;
        issue(0, 1, 8'h02, ERR_SPD_DELAY);
        req.delay = 8'h01;
        issue(0, 1, 8'h0A, ERR_SPD_LEADER);
        for (i = 2; i < 10; i++) begin
            // Only the selected counter channel moves, so a wrong decode
            // leaves the follower waiting
            cspd = {224'h0, 32'h0000_0064} << (32 * (i - 2));
            issue(0, 1, i[7:0], STAT_OK);
            chk(sv, 2'h2);
            halt();
        end
        cspd = '0;
        req.ratio = 14'h1388;
        issue(0, 1, 8'h00, STAT_OK);
        chk({inh, sv}, 4'h8);
        run = 1;
        // Two delay spans let the ramp settle on the scaled speed
        repeat (40) @(negedge clk);
        chk({sv, fspd[63:32]}, {2'h2, 32'h0000_0032});
        halt();
        chk(busy, 2'h0);
        end_of_test();
    end
    // Watchdog, far beyond the expected run of about 120 cycles
    initial begin
        #100000;
        bad_count++;
        end_of_test();
    end
endmodule
